/* rtl/ccrf_core_regs.v */
// Programmer-visible core registers, flags, stack pointer and context sequencer.
// Assumes decode issues one operation per cycle only while busy is low, and a
// stack memory whose read data follows the registered address combinationally.
`timescale 1ns/100ps
`default_nettype none
`include "ccrf_defines.vh"

module ccrf_core_regs (
    // Clock and reset
    input  wire        core_clk,
    input  wire        reset,
    // Operation from decode
    input  wire        op_valid,
    input  wire [4:0]  op_code,
    input  wire [1:0]  op_sel,
    input  wire [7:0]  op_data,
    input  wire [15:0] op_addr,
    input  wire        pc_inc,
    // Interrupt requests
    input  wire        irq_req,
    input  wire        trap_req,
    input  wire [15:0] irq_vector,
    output reg         irq_ack_q,
    // Stack memory
    output reg         stk_we_q,
    output reg  [15:0] stk_addr_q,
    output reg  [7:0]  stk_wdata_q,
    input  wire [7:0]  stk_rdata,
    // Register views
    output reg  [7:0]  acc_q, // RQ1
    output reg  [7:0]  x_q,
    output reg  [7:0]  y_q,
    output reg  [7:0]  flag_register_q,
    output reg  [15:0] instr_pointer_q,
    output reg  [15:0] stack_pointer_q,
    output reg         branch_taken_q,
    output reg         busy_q
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_PUSH = 4'b0010;
    localparam [3:0] ST_POPA = 4'b0100;
    localparam [3:0] ST_POPD = 4'b1000;

    reg  [3:0]  state_q;
    reg  [2:0]  kind_q;
    reg  [2:0]  step_q;
    reg  [1:0]  sel_q;
    reg  [15:0] target_q;
    reg         irq_pend_q;
    reg         trap_pend_q;

    reg  [7:0]  flag_d;
    reg         res_we;
    reg  [7:0]  res_val;
    reg         take_d;
    reg  [7:0]  sel_val;
    reg  [2:0]  slot;
    reg  [2:0]  last;
    reg  [7:0]  slot_byte;
    reg  [7:0]  sp_next;

    wire [7:0]  instr_pointer_low_byte  = instr_pointer_q[7:0];
    wire [7:0]  instr_pointer_high_byte = instr_pointer_q[15:8];
    wire        in_idle   = (state_q == ST_IDLE);
    wire        op_take   = op_valid & in_idle;
    wire        mask      = flag_register_q[`CCRF_BIT_I];
    wire [7:0]  alu_b     = (op_code == `CCRF_OP_MUL) ? acc_q : op_data;
    wire [15:0] br_target = instr_pointer_q + {{8{op_data[7]}}, op_data};
    wire [7:0]  alu_res;
    wire [7:0]  alu_hi;
    wire        alu_h;
    wire        alu_c;

    ccrf_alu u_alu (
        .op    (op_code),
        .a     (sel_val),
        .b     (alu_b),
        .cin   (flag_register_q[`CCRF_BIT_C]),
        .res   (alu_res),
        .hi    (alu_hi),
        .half  (alu_h),
        .carry (alu_c)
    );

    // Operand select
    always @* begin
        case (op_sel)
            `CCRF_SEL_A: sel_val = acc_q; // RQ2
            `CCRF_SEL_X: sel_val = x_q;   // RQ3
            `CCRF_SEL_Y: sel_val = y_q;   // RQ3
            default:     sel_val = flag_register_q;
        endcase
    end

    // Stack slot for the current sequence step
    always @* begin
        case (kind_q)
            `CCRF_K_INT:  slot = step_q; // RQ20
            `CCRF_K_CALL: slot = step_q; // RQ20
            `CCRF_K_INTERRUPT_RETURN_OP: slot = `CCRF_LAST_CTX - step_q;
            `CCRF_K_RET:  slot = `CCRF_LAST_RET - step_q;
            default: begin
                case (sel_q)
                    `CCRF_SEL_A: slot = `CCRF_SLOT_A;
                    `CCRF_SEL_X: slot = `CCRF_SLOT_X;
                    `CCRF_SEL_Y: slot = `CCRF_SLOT_Y;
                    default:     slot = `CCRF_SLOT_CC; // RQ7
                endcase
            end
        endcase
        case (kind_q)
            `CCRF_K_INT, `CCRF_K_INTERRUPT_RETURN_OP: last = `CCRF_LAST_CTX; // RQ4
            `CCRF_K_CALL, `CCRF_K_RET: last = `CCRF_LAST_RET;
            default:                   last = 3'h0;
        endcase
        case (slot)
            `CCRF_SLOT_PCL: slot_byte = instr_pointer_low_byte;
            `CCRF_SLOT_PCH: slot_byte = instr_pointer_high_byte;
            `CCRF_SLOT_X:   slot_byte = x_q;
            `CCRF_SLOT_A:   slot_byte = acc_q;
            `CCRF_SLOT_CC:  slot_byte = flag_register_q;
            default:        slot_byte = y_q;
        endcase
    end

    // Flag and result update for one operation
    always @* begin
        flag_d  = flag_register_q;
        res_we  = 1'b0;
        res_val = alu_res;
        take_d  = 1'b0;
        case (op_code)
            `CCRF_OP_LD: begin
                if (op_sel == `CCRF_SEL_CC) begin
                    flag_d = {`CCRF_FLAG_TOP, op_data[4:0]}; // RQ21
                end else begin
                    res_we  = 1'b1;
                    res_val = op_data;
                    flag_d[`CCRF_BIT_N] = op_data[7];        // RQ14
                    flag_d[`CCRF_BIT_Z] = (op_data == 8'h00); // RQ15
                end
            end
            `CCRF_OP_ADD, `CCRF_OP_ADC, `CCRF_OP_SUB, `CCRF_OP_SBC,
            `CCRF_OP_SHL, `CCRF_OP_SHR, `CCRF_OP_ROL, `CCRF_OP_ROR,
            `CCRF_OP_AND, `CCRF_OP_OR, `CCRF_OP_XOR: begin
                res_we = (op_sel != `CCRF_SEL_CC);
                flag_d[`CCRF_BIT_N] = alu_res[7];          // RQ14
                flag_d[`CCRF_BIT_Z] = (alu_res == 8'h00);  // RQ15
                if (op_code == `CCRF_OP_ADD || op_code == `CCRF_OP_ADC) begin
                    flag_d[`CCRF_BIT_H] = alu_h;           // RQ8
                end
                if (op_code != `CCRF_OP_AND && op_code != `CCRF_OP_OR &&
                    op_code != `CCRF_OP_XOR) begin
                    flag_d[`CCRF_BIT_C] = alu_c;           // RQ16
                end
            end
            `CCRF_OP_MUL: begin
                flag_d[`CCRF_BIT_H] = 1'b0; // RQ18
                flag_d[`CCRF_BIT_C] = 1'b0;
            end
            `CCRF_OP_BTJ: begin
                flag_d[`CCRF_BIT_C] = op_data[op_addr[2:0]];                // RQ17
                take_d = (op_data[op_addr[2:0]] == op_addr[3]);
            end
            `CCRF_OP_SCF: flag_d[`CCRF_BIT_C] = 1'b1; // RQ16
            `CCRF_OP_RCF: flag_d[`CCRF_BIT_C] = 1'b0; // RQ16
            `CCRF_OP_SIM: flag_d[`CCRF_BIT_I] = 1'b1; // RQ10
            `CCRF_OP_RIM: flag_d[`CCRF_BIT_I] = 1'b0; // RQ10
            `CCRF_OP_JR:  take_d = (flag_register_q[op_addr[2:0]] == op_addr[3]); // RQ9
            default:      flag_d = flag_register_q;
        endcase
    end

    always @* begin
        sp_next = stack_pointer_q[7:0] + 8'h01;
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q         <= ST_IDLE;
            kind_q          <= `CCRF_K_INT;
            step_q          <= 3'h0;
            sel_q           <= `CCRF_SEL_A;
            target_q        <= 16'h0000;
            irq_pend_q      <= 1'b0;
            trap_pend_q     <= 1'b0;
            irq_ack_q       <= 1'b0;
            stk_we_q        <= 1'b0;
            stk_addr_q      <= 16'h0000;
            stk_wdata_q     <= 8'h00;
            acc_q           <= 8'h00;
            x_q             <= 8'h00;
            y_q             <= 8'h00;
            flag_register_q <= `CCRF_FLAG_RST; // RQ6
            instr_pointer_q <= `CCRF_PC_RST;
            stack_pointer_q <= {`CCRF_SP_HIGH, `CCRF_SP_LOW};
            branch_taken_q  <= 1'b0;
            busy_q          <= 1'b0;
        end else begin
            stk_we_q       <= 1'b0;
            irq_ack_q      <= 1'b0;
            branch_taken_q <= 1'b0;
            stack_pointer_q[15:8] <= `CCRF_SP_HIGH; // RQ19
            case (state_q)
                ST_IDLE: begin
                    step_q <= 3'h0;
                    if (pc_inc) begin
                        instr_pointer_q <= instr_pointer_q + 16'h0001; // RQ5
                    end
                    if (op_valid) begin
                        flag_register_q <= flag_d;
                        if (res_we) begin
                            case (op_sel)
                                `CCRF_SEL_A: acc_q <= res_val;
                                `CCRF_SEL_X: x_q   <= res_val;
                                default:     y_q   <= res_val;
                            endcase
                        end
                        if (take_d) begin
                            instr_pointer_q <= br_target; // RQ9
                            branch_taken_q  <= 1'b1;
                        end
                        case (op_code)
                            `CCRF_OP_MUL: begin
                                x_q   <= alu_hi; // RQ18
                                acc_q <= alu_res;
                            end
                            `CCRF_OP_JP: instr_pointer_q <= op_addr;
                            `CCRF_OP_RSP: stack_pointer_q[7:0] <= `CCRF_SP_LOW;
                            `CCRF_OP_CALL, `CCRF_OP_PUSH: begin
                                state_q  <= ST_PUSH;
                                busy_q   <= 1'b1;
                                sel_q    <= op_sel;
                                target_q <= op_addr;
                                kind_q   <= (op_code == `CCRF_OP_CALL) ? `CCRF_K_CALL
                                                                       : `CCRF_K_ONE;
                            end
                            `CCRF_OP_INTERRUPT_RETURN_OP, `CCRF_OP_RET, `CCRF_OP_POP: begin
                                state_q <= ST_POPA;
                                busy_q  <= 1'b1;
                                sel_q   <= op_sel;
                                if (op_code == `CCRF_OP_INTERRUPT_RETURN_OP) begin
                                    kind_q <= `CCRF_K_INTERRUPT_RETURN_OP;
                                end else if (op_code == `CCRF_OP_RET) begin
                                    kind_q <= `CCRF_K_RET;
                                end else begin
                                    kind_q <= `CCRF_K_ONE;
                                end
                            end
                            default: busy_q <= 1'b0;
                        endcase
                    end else if (trap_pend_q || trap_req || (irq_pend_q && !mask)) begin // RQ11 RQ13
                        // Trap ignores the mask; maskable request waits for it
                        state_q   <= ST_PUSH;
                        kind_q    <= `CCRF_K_INT;
                        busy_q    <= 1'b1;
                        target_q  <= irq_vector;
                        irq_ack_q <= 1'b1;
                        if (trap_pend_q || trap_req) begin
                            trap_pend_q <= 1'b0;
                        end else begin
                            irq_pend_q <= 1'b0;
                        end
                    end
                end
                ST_PUSH: begin
                    stk_we_q             <= 1'b1;
                    stk_addr_q           <= stack_pointer_q;
                    stk_wdata_q          <= slot_byte;
                    stack_pointer_q[7:0] <= stack_pointer_q[7:0] - 8'h01; // RQ19
                    step_q               <= step_q + 3'h1;
                    if (step_q == last) begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                        if (kind_q == `CCRF_K_INT) begin
                            flag_register_q[`CCRF_BIT_I] <= 1'b1; // RQ10
                            instr_pointer_q <= target_q;
                        end else if (kind_q == `CCRF_K_CALL) begin
                            instr_pointer_q <= target_q;
                        end
                    end
                end
                ST_POPA: begin
                    stack_pointer_q[7:0] <= sp_next; // RQ19
                    stk_addr_q           <= {`CCRF_SP_HIGH, sp_next};
                    state_q              <= ST_POPD;
                end
                ST_POPD: begin
                    case (slot)
                        `CCRF_SLOT_PCL: instr_pointer_q[7:0]  <= stk_rdata;
                        `CCRF_SLOT_PCH: instr_pointer_q[15:8] <= stk_rdata;
                        `CCRF_SLOT_X:   x_q   <= stk_rdata;
                        `CCRF_SLOT_A:   acc_q <= stk_rdata;
                        `CCRF_SLOT_CC: begin
                            flag_register_q <= {`CCRF_FLAG_TOP, stk_rdata[4:0]}; // RQ7
                            if (kind_q == `CCRF_K_INTERRUPT_RETURN_OP) begin
                                flag_register_q[`CCRF_BIT_I] <= 1'b0; // RQ12
                            end
                        end
                        default:        y_q <= stk_rdata;
                    endcase
                    step_q <= step_q + 3'h1;
                    if (step_q == last) begin
                        state_q <= ST_IDLE;
                        busy_q  <= 1'b0;
                    end else begin
                        state_q <= ST_POPA;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    busy_q  <= 1'b0;
                end
            endcase
            // Set after clear so a new request is never lost
            if (irq_req) begin
                irq_pend_q <= 1'b1; // RQ11
            end
            if (trap_req && !(in_idle && !op_valid && !trap_pend_q)) begin
                trap_pend_q <= 1'b1;
            end
        end
    end

endmodule // ccrf_core_regs
`default_nettype wire

/* rtl/ccrf_defines.vh */
// Constants for the core register set: operations, selects, flag bits, resets.
// Assumes inclusion by the core register, ALU and bench files only.
//
// Behaviour
// RQ1 - Six core registers, reachable only by operations
// RQ2 - Working register feeds and receives ALU results
// RQ3 - Two index registers, also temporary storage
// RQ4 - Second index register never stacked on interrupts
// RQ5 - Sixteen-bit instruction pointer from two bytes
// RQ6 - Flag bits H,I,N,Z,C; top ones; reset 111x1010
// RQ7 - Flags pushable, poppable, each bit testable
// RQ8 - Nibble carry follows bit-3 carry on adds
// RQ9 - Branches test every flag in both polarities
// RQ10 - Mask set by entry or op, cleared by op
// RQ11 - Masked requests stay pending until unmasked
// RQ12 - Interrupt return clears the mask flag
// RQ13 - Clearing mask in routine services pending at once
// RQ14 - Sign flag copies result bit seven
// RQ15 - Null flag set on zero result
// RQ16 - Overflow from arithmetic; forced by set/drop ops
// RQ17 - Overflow also from bit-test, shifts, rotates
// RQ18 - Single-cycle unsigned eight-by-eight multiply
// RQ19 - Stack pointer high byte fixed, wraps, post-dec push
// RQ20 - Interrupt pushes five bytes low pointer first; call two
// RQ21 - Writes to upper three flag bits ignored
`ifndef CCRF_DEFINES_VH
`define CCRF_DEFINES_VH

// Operation codes
`define CCRF_OP_NOP   5'h00
`define CCRF_OP_LD    5'h01
`define CCRF_OP_ADD   5'h02
`define CCRF_OP_ADC   5'h03
`define CCRF_OP_SUB   5'h04
`define CCRF_OP_SBC   5'h05
`define CCRF_OP_AND   5'h06
`define CCRF_OP_OR    5'h07
`define CCRF_OP_XOR   5'h08
`define CCRF_OP_SHL   5'h09
`define CCRF_OP_SHR   5'h0a
`define CCRF_OP_ROL   5'h0b
`define CCRF_OP_ROR   5'h0c
`define CCRF_OP_MUL   5'h0d
`define CCRF_OP_BTJ   5'h0e
`define CCRF_OP_SCF   5'h0f
`define CCRF_OP_RCF   5'h10
`define CCRF_OP_SIM   5'h11
`define CCRF_OP_RIM   5'h12
`define CCRF_OP_INTERRUPT_RETURN_OP  5'h13
`define CCRF_OP_CALL  5'h14
`define CCRF_OP_RET   5'h15
`define CCRF_OP_PUSH  5'h16
`define CCRF_OP_POP   5'h17
`define CCRF_OP_JR    5'h18
`define CCRF_OP_RSP   5'h19
`define CCRF_OP_JP    5'h1a

// Register selects
`define CCRF_SEL_A    2'h0
`define CCRF_SEL_X    2'h1
`define CCRF_SEL_Y    2'h2
`define CCRF_SEL_CC   2'h3

// Flag bit positions
`define CCRF_BIT_C    0
`define CCRF_BIT_Z    1
`define CCRF_BIT_N    2
`define CCRF_BIT_I    3
`define CCRF_BIT_H    4

// Reset values
`define CCRF_FLAG_RST  8'hea
`define CCRF_FLAG_TOP  3'h7
`define CCRF_SP_HIGH   8'h01
`define CCRF_SP_LOW    8'hff
`define CCRF_PC_RST    16'hfffe

// Stack slots
`define CCRF_SLOT_PCL  3'h0
`define CCRF_SLOT_PCH  3'h1
`define CCRF_SLOT_X    3'h2
`define CCRF_SLOT_A    3'h3
`define CCRF_SLOT_CC   3'h4
`define CCRF_SLOT_Y    3'h5

// Sequence kinds and their last step
`define CCRF_K_INT    3'h0
`define CCRF_K_CALL   3'h1
`define CCRF_K_ONE    3'h2
`define CCRF_K_INTERRUPT_RETURN_OP   3'h3
`define CCRF_K_RET    3'h4
`define CCRF_LAST_CTX 3'h4
`define CCRF_LAST_RET 3'h1

`endif

/* rtl/ccrf_alu.v */
// Combinational arithmetic and logic unit of the core.
// Assumes the caller registers its outputs and picks which flags to keep.
`timescale 1ns/100ps
`default_nettype none
`include "ccrf_defines.vh"

module ccrf_alu (
    // Operation and operands
    input  wire [4:0] op,
    input  wire [7:0] a,
    input  wire [7:0] b,
    input  wire       cin,
    // Results
    output reg  [7:0] res,
    output reg  [7:0] hi,
    output reg        half,
    output reg        carry
);

    reg [8:0]  t;
    reg [4:0]  n;
    reg [15:0] p;

    always @* begin
        t     = 9'h000;
        n     = 5'h00;
        p     = 16'h0000;
        res   = a;
        hi    = 8'h00;
        half  = 1'b0;
        carry = cin;
        case (op)
            `CCRF_OP_ADD, `CCRF_OP_ADC: begin
                t = {1'b0, a} + {1'b0, b} + {8'h00, cin & (op == `CCRF_OP_ADC)};
                n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin & (op == `CCRF_OP_ADC)};
                res   = t[7:0];
                carry = t[8];
                half  = n[4]; // RQ8
            end
            `CCRF_OP_SUB, `CCRF_OP_SBC: begin
                t = {1'b0, a} - {1'b0, b} - {8'h00, cin & (op == `CCRF_OP_SBC)};
                res   = t[7:0];
                carry = t[8];
            end
            `CCRF_OP_AND: res = a & b;
            `CCRF_OP_OR:  res = a | b;
            `CCRF_OP_XOR: res = a ^ b;
            `CCRF_OP_SHL: begin
                res   = {a[6:0], 1'b0};
                carry = a[7]; // RQ17
            end
            `CCRF_OP_SHR: begin
                res   = {1'b0, a[7:1]};
                carry = a[0]; // RQ17
            end
            `CCRF_OP_ROL: begin
                res   = {a[6:0], cin};
                carry = a[7]; // RQ17
            end
            `CCRF_OP_ROR: begin
                res   = {cin, a[7:1]};
                carry = a[0]; // RQ17
            end
            `CCRF_OP_MUL: begin
                p     = {8'h00, a} * {8'h00, b}; // RQ18
                res   = p[7:0];
                hi    = p[15:8];
                carry = 1'b0;
            end
            default: res = a;
        endcase
    end

endmodule // ccrf_alu
`default_nettype wire

/* tb/ccrf_core_regs_checker.sv */
// Concurrent checks on the ports of the core register set.
// Assumes binding onto ccrf_core_regs, one clock domain, async reset high.
`timescale 1ns/100ps
`default_nettype none
module ccrf_checker (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // Observed ports
    input wire logic [7:0]  op_data,
    input wire logic        irq_ack_q,
    input wire logic        stk_we_q,
    input wire logic [15:0] stk_addr_q,
    input wire logic [7:0]  y_q,
    input wire logic [7:0]  flag_register_q,
    input wire logic [15:0] instr_pointer_q,
    input wire logic [15:0] stack_pointer_q,
    input wire logic        branch_taken_q
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    top_ones_a: assert property (flag_register_q[7:5] == 3'h7)
        else $error("flag top bits not all one");
    stack_page_a: assert property (stack_pointer_q[15:8] == 8'h01)
        else $error("stack page changed");
    entry_mask_a: assert property (irq_ack_q |-> ##[1:6] flag_register_q[3])
        else $error("mask not set on entry");
    ctx_writes_a: assert property (irq_ack_q |=> stk_we_q [*5])
        else $error("entry did not write five bytes");
    ctx_start_a: assert property (irq_ack_q |=> stk_addr_q == $past(stack_pointer_q))
        else $error("entry first write not at stack top");
    push_dec_a: assert property (stk_we_q |-> stack_pointer_q[7:0] == stk_addr_q[7:0] - 8'h01)
        else $error("stack pointer not one below write");
    second_index_a: assert property (irq_ack_q |=> $stable(y_q) [*5])
        else $error("second index changed on entry");
    branch_dest_a: assert property (branch_taken_q |-> instr_pointer_q ==
        $past(instr_pointer_q) + {{8{$past(op_data[7])}}, $past(op_data)})
        else $error("branch target wrong");
endmodule // ccrf_checker

bind ccrf_core_regs ccrf_checker u_chk (
    .core_clk(core_clk), .reset(reset), .op_data(op_data), .irq_ack_q(irq_ack_q),
    .stk_we_q(stk_we_q), .stk_addr_q(stk_addr_q), .y_q(y_q),
    .flag_register_q(flag_register_q), .instr_pointer_q(instr_pointer_q),
    .stack_pointer_q(stack_pointer_q), .branch_taken_q(branch_taken_q)
);
`default_nettype wire

/* tb/tb_ccrf_core_regs.sv */
// Self-checking bench for the core register set with a stack memory model.
// Assumes rtl/ on the include path and the checker bound to the design.
`timescale 1ns/100ps
`default_nettype none
`include "ccrf_defines.vh"
module tb_ccrf_core_regs;
    localparam logic [4:0] op_force_ovf = 5'h0f, op_drop_ovf = 5'h10;
    localparam logic [4:0] op_mask_on = 5'h11, op_mask_off = 5'h12, op_int_ret = 5'h13;
    localparam logic [1:0] sel_flags = 2'h3;
    logic        core_clk = 0, reset = 1, op_valid = 0, pc_inc = 0, irq_req = 0, trap_req = 0;
    logic [4:0]  op_code = 0;
    logic [1:0]  op_sel = 0;
    logic [7:0]  op_data = 0, d, b, f, r;
    logic [15:0] op_addr = 0, irq_vector = 0, pc0, s0;
    logic [8:0]  sum;
    logic        bt, h;
    logic        irq_ack_q, stk_we_q, branch_taken_q, busy_q;
    logic [15:0] stk_addr_q, instr_pointer_q, stack_pointer_q;
    logic [7:0]  stk_wdata_q, acc_q, x_q, y_q, flag_register_q;
    logic [7:0]  mem [0:255];
    wire  [7:0]  stk_rdata = mem[stk_addr_q[7:0]];
    int          miscompares = 0, checks_done = 0, cyc = 0, acks = 0, a0;

    ccrf_core_regs u_dut (
        .core_clk(core_clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
        .op_sel(op_sel), .op_data(op_data), .op_addr(op_addr), .pc_inc(pc_inc),
        .irq_req(irq_req), .trap_req(trap_req), .irq_vector(irq_vector),
        .irq_ack_q(irq_ack_q), .stk_we_q(stk_we_q), .stk_addr_q(stk_addr_q),
        .stk_wdata_q(stk_wdata_q), .stk_rdata(stk_rdata), .acc_q(acc_q), .x_q(x_q),
        .y_q(y_q), .flag_register_q(flag_register_q), .instr_pointer_q(instr_pointer_q),
        .stack_pointer_q(stack_pointer_q), .branch_taken_q(branch_taken_q), .busy_q(busy_q)
    );

    always #5 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        if (stk_we_q === 1'b1) mem[stk_addr_q[7:0]] <= stk_wdata_q;
        if (irq_ack_q === 1'b1) acks <= acks + 1;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test;
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (miscompares == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // One operation, then wait until any stack sequence has finished
    task automatic run_op(input logic [4:0] c, input logic [1:0] s, input logic [7:0] dt,
                          input logic [15:0] ad);
        @(posedge core_clk);
        op_valid <= 1; op_code <= c; op_sel <= s; op_data <= dt; op_addr <= ad;
        @(posedge core_clk);
        op_valid <= 0;
        #1 bt = branch_taken_q;
        @(posedge core_clk);
        #1;
        for (int n = 0; n < 20 && busy_q !== 1'b0; n++) @(posedge core_clk) #1;
    endtask

    task automatic wait_entry;
        for (int n = 0; n < 40 && !(acks == a0 + 1 && busy_q === 1'b0); n++)
            @(posedge core_clk) #1;
        chk(acks, a0 + 1);
        chk(instr_pointer_q, irq_vector);
        chk({8'h00, flag_register_q[3]}, 16'h0001);
    endtask

    initial begin
        void'($urandom(83064));
        irq_vector <= $urandom;
        repeat (5) @(posedge core_clk);
        reset <= 0;
        @(posedge core_clk) #1;
        chk({8'h00, flag_register_q & 8'hef}, 16'h00ea);
        chk(stack_pointer_q, 16'h01ff);
        chk({acc_q, x_q}, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : $urandom;
            run_op(`CCRF_OP_LD, `CCRF_SEL_A, d, 0);
            chk({8'h00, acc_q}, {8'h00, d});
            chk({14'h0000, flag_register_q[2:1]}, {14'h0000, d[7], d == 8'h00});
            b = $urandom;
            run_op(`CCRF_OP_LD, i[0] ? `CCRF_SEL_X : `CCRF_SEL_Y, b, 0);
            chk({8'h00, i[0] ? x_q : y_q}, {8'h00, b});
        end
        for (int i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'h08 : (i == 1) ? 8'hff : $urandom;
            b = (i == 0) ? 8'h08 : (i == 1) ? 8'h01 : $urandom;
            sum = {1'b0, d} + {1'b0, b};
            h = ({1'b0, d[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
            run_op(`CCRF_OP_LD, `CCRF_SEL_A, d, 0);
            run_op(`CCRF_OP_ADD, `CCRF_SEL_A, b, 0);
            chk({8'h00, acc_q}, {8'h00, sum[7:0]});
            chk({12'h000, flag_register_q[4], flag_register_q[2:0]},
                {12'h000, h, sum[7], sum[7:0] == 8'h00, sum[8]});
            run_op(`CCRF_OP_SHL, `CCRF_SEL_A, 0, 0);
            chk({7'h00, flag_register_q[0], acc_q}, {7'h00, sum[7], sum[6:0], 1'b0});
            d = $urandom;
            run_op(`CCRF_OP_BTJ, `CCRF_SEL_A, d, {12'h000, i[0], i[2:0]});
            chk({14'h0000, flag_register_q[0], bt}, {14'h0000, d[i], d[i] == i[0]});
        end
        run_op(op_force_ovf, `CCRF_SEL_A, 0, 0);
        chk({8'h00, flag_register_q[0]}, 16'h0001);
        run_op(op_drop_ovf, `CCRF_SEL_A, 0, 0);
        chk({8'h00, flag_register_q[0]}, 16'h0000);
        run_op(op_mask_off, `CCRF_SEL_A, 0, 0);
        chk({8'h00, flag_register_q[3]}, 16'h0000);
        run_op(`CCRF_OP_LD, sel_flags, 8'h00, 0);
        chk({8'h00, flag_register_q}, 16'h00e0);
        run_op(`CCRF_OP_LD, sel_flags, 8'hff, 0);
        chk({8'h00, flag_register_q}, 16'h00ff);
        for (int k = 0; k < 10; k++) begin
            f = $urandom;
            d = $urandom;
            run_op(`CCRF_OP_LD, sel_flags, f, 0);
            pc0 = instr_pointer_q;
            run_op(`CCRF_OP_JR, `CCRF_SEL_A, d, {12'h000, k[0], 3'(k / 2)});
            chk({15'h0000, bt}, {15'h0000, f[k / 2] == k[0]});
            chk(instr_pointer_q, (f[k / 2] == k[0]) ? pc0 + {{8{d[7]}}, d} : pc0);
        end
        run_op(`CCRF_OP_JP, `CCRF_SEL_A, 0, 16'h1234);
        chk(instr_pointer_q, 16'h1234);
        @(posedge core_clk) pc_inc <= 1;
        @(posedge core_clk) pc_inc <= 0;
        #1 chk(instr_pointer_q, 16'h1235);
        d = $urandom;
        b = $urandom;
        run_op(`CCRF_OP_LD, `CCRF_SEL_X, d, 0);
        run_op(`CCRF_OP_LD, `CCRF_SEL_A, b, 0);
        run_op(`CCRF_OP_MUL, `CCRF_SEL_X, 0, 0);
        chk({x_q, acc_q}, {8'h00, d} * {8'h00, b});
        f = $urandom;
        run_op(`CCRF_OP_LD, sel_flags, f | 8'h08, 0);
        run_op(`CCRF_OP_PUSH, sel_flags, 0, 0);
        chk(stack_pointer_q, 16'h01fe);
        run_op(`CCRF_OP_LD, sel_flags, ~f, 0);
        run_op(`CCRF_OP_POP, sel_flags, 0, 0);
        chk({8'h00, flag_register_q}, {8'h00, 3'h7, f[4] , 1'b1, f[2:0]});
        chk(stack_pointer_q, 16'h01ff);
        r = $urandom;
        run_op(`CCRF_OP_LD, `CCRF_SEL_Y, r, 0);
        run_op(op_mask_on, `CCRF_SEL_A, 0, 0);
        a0 = acks;
        @(posedge core_clk) irq_req <= 1;
        @(posedge core_clk) irq_req <= 0;
        repeat (10) @(posedge core_clk);
        #1 chk(acks, a0);
        pc0 = instr_pointer_q;
        run_op(op_mask_off, `CCRF_SEL_A, 0, 0);
        wait_entry;
        chk({mem[8'hfe], mem[8'hff]}, {pc0[15:8], pc0[7:0]});
        chk({8'h00, mem[8'hfb][3]}, 16'h0000);
        chk(stack_pointer_q, 16'h01fa);
        chk({8'h00, y_q}, {8'h00, r});
        run_op(op_int_ret, `CCRF_SEL_A, 0, 0);
        chk(instr_pointer_q, pc0);
        chk({8'h00, flag_register_q[3]}, 16'h0000);
        run_op(op_mask_on, `CCRF_SEL_A, 0, 0);
        a0 = acks;
        @(posedge core_clk) trap_req <= 1;
        @(posedge core_clk) trap_req <= 0;
        wait_entry;
        run_op(op_int_ret, `CCRF_SEL_A, 0, 0);
        pc0 = instr_pointer_q;
        run_op(`CCRF_OP_CALL, `CCRF_SEL_A, 0, 16'h2345);
        chk(instr_pointer_q, 16'h2345);
        chk(stack_pointer_q, 16'h01fd);
        chk({mem[8'hfe], mem[8'hff]}, {pc0[15:8], pc0[7:0]});
        run_op(`CCRF_OP_RET, `CCRF_SEL_A, 0, 0);
        chk(instr_pointer_q, pc0);
        end_of_test;
    end
endmodule // tb_ccrf_core_regs
`default_nettype wire
